// ---- rtl/utr_pkg.sv ----
package utr_pkg;

  // ==========================================================
  // Register map
  localparam logic [15:0] UTR_OFS_MODE = 16'hFF50;
  localparam logic [15:0] UTR_OFS_RXB = 16'hFF52;
  localparam logic [15:0] UTR_OFS_ERR = 16'hFF53;
  localparam logic [15:0] UTR_OFS_TXB = 16'hFF54;
  localparam logic [15:0] UTR_OFS_TXS = 16'hFF55;

  localparam logic [7:0] UTR_MODE_RST = 8'h01;
  localparam logic [7:0] UTR_RXB_RST = 8'hFF;
  localparam logic [7:0] UTR_TXB_RST = 8'hFF;

  // ==========================================================
  // Field positions
  localparam int UTR_MODE_POWER = 7;
  localparam int UTR_MODE_TXE = 6;
  localparam int UTR_MODE_RXE = 5;
  localparam int UTR_MODE_PS_HI = 4;
  localparam int UTR_MODE_PS_LO = 3;
  localparam int UTR_MODE_CL = 2;
  localparam int UTR_MODE_SL = 1;
  localparam int UTR_MODE_ROUTE = 0;
  localparam int UTR_ERR_PE = 2;
  localparam int UTR_ERR_FE = 1;
  localparam int UTR_ERR_OVE = 0;
  localparam int UTR_TXS_FULL = 1;
  localparam int UTR_TXS_BUSY = 0;

  // ==========================================================
  // Timing and sizes
  localparam int UTR_BIT_CYCLES = 16;
  localparam int UTR_FIFO_DEPTH = 8;
  localparam int UTR_FIFO_WIDTH = 10;
  localparam int UTR_FRAME_W = 12;

  typedef enum logic [1:0] {
    UTR_PAR_NONE = 2'b00,
    UTR_PAR_ZERO = 2'b01,
    UTR_PAR_ODD = 2'b10,
    UTR_PAR_EVEN = 2'b11
  } utr_parity_e;

  typedef enum logic [2:0] {
    UTR_RX_IDLE = 3'b000,
    UTR_RX_START = 3'b001,
    UTR_RX_DATA = 3'b010,
    UTR_RX_PAR = 3'b011,
    UTR_RX_STOP = 3'b100
  } utr_rx_e;

  // Unused data bits are zero, so one XOR serves both lengths
  function automatic logic utr_parity(input logic [7:0] b,
                                      input logic [1:0] ps);
    case (ps)
      UTR_PAR_ODD: return ~^b;
      UTR_PAR_EVEN: return ^b;
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic utr_hit(input logic [15:0] a,
                                   input logic [15:0] o);
    return a == o;
  endfunction

endpackage

// ---- rtl/utr_fifo.sv ----
`timescale 1ns/100ps
module utr_fifo #(
  parameter int WIDTH = utr_pkg::UTR_FIFO_WIDTH,
  parameter int DEPTH = utr_pkg::UTR_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic clear_in,
  // Fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  import utr_pkg::*;

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } utr_fifo_s;

  utr_fifo_s q;
  utr_fifo_s d;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] utr_inc(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  assign in_ready_out = q.cnt != (AW + 1)'(DEPTH);
  assign out_valid_out = q.cnt != '0;
  assign out_data_out = q.mem[q.rp];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  // ==========================================================
  // Next state
  always_comb begin
    d = q;
    if (clear_in) begin
      d.wp = '0;
      d.rp = '0;
      d.cnt = '0;
    end else begin
      if (push) begin
        d.mem[q.wp] = in_data_in;
        d.wp = utr_inc(q.wp);
      end
      if (pop) begin
        d.rp = utr_inc(q.rp);
      end
      d.cnt = (AW + 1)'(q.cnt + (AW + 1)'(push) - (AW + 1)'(pop));
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule

// ---- rtl/utr_core.sv ----
`timescale 1ns/100ps
module utr_core #(
  parameter int BIT_CYCLES = utr_pkg::UTR_BIT_CYCLES,
  parameter int FIFO_DEPTH = utr_pkg::UTR_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // CPU register port
  input wire logic [15:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  // Serial link
  input wire logic serial_in_pin_in,
  output logic serial_out_pin_out,
  // Bit order
  input wire logic msb_first_in,
  // Interrupt requests
  output logic rx_done_irq_out,
  output logic rx_error_irq_out,
  output logic tx_done_irq_out
);
  import utr_pkg::*;

  localparam int CW = (BIT_CYCLES > 1) ? $clog2(BIT_CYCLES) : 1;
  localparam logic [CW-1:0] CNT_LAST = CW'(BIT_CYCLES - 1);
  localparam logic [CW-1:0] CNT_HALF = CW'(BIT_CYCLES / 2 - 1);

  // ==========================================================
  // State
  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] txb;
    logic [7:0] rdata;
  } utr_regs_s;

  typedef struct packed {
    utr_rx_e rx_state;
    logic [CW-1:0] rx_cnt;
    logic [3:0] rx_bits;
    logic [7:0] rx_shifter;
    logic rx_par;
    logic [7:0] rx_holding_reg;
    logic rx_full;
    logic [2:0] rx_error_status;
    logic rx_done;
    logic rx_err_irq;
    logic [UTR_FRAME_W-1:0] tx_shifter;
    logic [CW-1:0] tx_cnt;
    logic [3:0] tx_bits;
    logic tx_busy;
    logic txbuf_full_flag;
    logic tx_out;
    logic tx_fin;
    logic tx_done;
  } utr_core_s;

  localparam utr_core_s CORE_RST = '{
    rx_state: UTR_RX_IDLE,
    rx_holding_reg: UTR_RXB_RST,
    tx_out: 1'b1,
    default: '0
  };

  utr_regs_s r;
  utr_regs_s rn;
  utr_core_s q;
  utr_core_s d;

  logic core_rst_n;
  logic power;
  logic tx_en;
  logic rx_en;
  logic len8;
  logic route;
  logic [1:0] ps;
  logic par_on;
  logic par_chk;
  logic rxd;
  logic rx_last;
  logic tx_last;
  logic wr_txb;
  logic rd_rxb;
  logic rd_err;
  logic [7:0] rx_data;
  logic rx_pe;
  logic rx_complete;
  logic rx_fe;
  logic overrun;
  logic pop;
  logic pop_err;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [UTR_FIFO_WIDTH-1:0] fifo_out;
  logic [7:0] tx_data;
  logic [UTR_FRAME_W-1:0] tx_frame;
  logic [3:0] tx_count;
  logic tx_end;
  logic tx_load;

  // ==========================================================
  // Mode decode
  // Power gates the core state and receive queue through their async reset; the mode,
  // transmit buffer and read data registers stay on the chip reset so software can re-enable
  assign power = r.mode[UTR_MODE_POWER];
  assign core_rst_n = rst_n_in & power;
  assign tx_en = r.mode[UTR_MODE_TXE];
  assign rx_en = r.mode[UTR_MODE_RXE];
  assign ps = {r.mode[UTR_MODE_PS_HI], r.mode[UTR_MODE_PS_LO]};
  assign par_on = ps != UTR_PAR_NONE;
  assign par_chk = ps == UTR_PAR_ODD || ps == UTR_PAR_EVEN;
  assign len8 = r.mode[UTR_MODE_CL];
  assign route = r.mode[UTR_MODE_ROUTE];
  assign rxd = power ? serial_in_pin_in : 1'b1;
  assign rx_last = q.rx_cnt == CNT_LAST;
  assign tx_last = q.tx_cnt == CNT_LAST;
  assign wr_txb = reg_wr_in && utr_hit(reg_addr_in, UTR_OFS_TXB);
  assign rd_rxb = reg_rd_in && utr_hit(reg_addr_in, UTR_OFS_RXB);
  assign rd_err = reg_rd_in && utr_hit(reg_addr_in, UTR_OFS_ERR);

  // ==========================================================
  // Receive assembly
  always_comb begin
    if (len8) begin
      rx_data = q.rx_shifter;
    end else if (msb_first_in) begin
      rx_data = {q.rx_shifter[6:0], 1'b0};
    end else begin
      rx_data = {1'b0, q.rx_shifter[7:1]};
    end
  end

  assign rx_pe = par_chk && (q.rx_par != utr_parity(rx_data, ps));
  assign rx_complete = rx_en && q.rx_state == UTR_RX_STOP && rx_last;
  assign rx_fe = !rxd;
  assign overrun = rx_complete && !fifo_in_ready;
  assign pop = fifo_out_valid && !q.rx_full;
  assign pop_err = fifo_out[9] || fifo_out[8];

  // Holding slot drains the queue only once software has read it
  utr_fifo #(
    .WIDTH(UTR_FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_in(clk_in),
    .rst_n_in(core_rst_n),
    .clear_in(!rx_en),
    .in_valid_in(rx_complete),
    .in_ready_out(fifo_in_ready),
    .in_data_in({rx_pe, rx_fe, rx_data}),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(!q.rx_full),
    .out_data_out(fifo_out)
  );

  // ==========================================================
  // Transmit frame
  always_comb begin
    if (msb_first_in) begin
      tx_data = {<<{r.txb}};
    end else begin
      tx_data = r.txb;
    end
    if (!len8) begin
      tx_data[7] = 1'b0;
    end
    tx_frame = '1;
    tx_frame[0] = 1'b0;
    tx_frame[7:1] = tx_data[6:0];
    if (len8) begin
      tx_frame[8] = tx_data[7];
      tx_frame[9] = par_on ? utr_parity(tx_data, ps) : 1'b1;
    end else begin
      tx_frame[8] = par_on ? utr_parity(tx_data, ps) : 1'b1;
    end
    // Start, seven data bits and one stop bit, plus the options
    tx_count = 4'h9 + 4'(len8) + 4'(par_on)
               + 4'(r.mode[UTR_MODE_SL]);
  end

  assign tx_end = q.tx_busy && tx_last && q.tx_bits == 4'h1;
  assign tx_load = tx_en && q.txbuf_full_flag
                   && (!q.tx_busy || tx_end);

  // ==========================================================
  // Core next state
  always_comb begin
    d = q;
    d.rx_done = 1'b0;
    d.rx_err_irq = 1'b0;
    d.tx_fin = 1'b0;
    d.tx_done = q.tx_fin;
    d.rx_cnt = rx_last ? '0 : CW'(q.rx_cnt + 1'b1);
    if (!rx_en) begin
      d.rx_state = UTR_RX_IDLE;
      d.rx_cnt = '0;
      d.rx_bits = '0;
    end else begin
      case (q.rx_state)
        UTR_RX_IDLE: begin
          d.rx_cnt = '0;
          if (!rxd) begin
            d.rx_state = UTR_RX_START;
          end
        end
        UTR_RX_START: begin
          if (q.rx_cnt == CNT_HALF) begin
            d.rx_cnt = '0;
            d.rx_bits = '0;
            d.rx_state = rxd ? UTR_RX_IDLE : UTR_RX_DATA;
          end
        end
        UTR_RX_DATA: begin
          if (rx_last) begin
            d.rx_shifter = msb_first_in ? {q.rx_shifter[6:0], rxd}
                                        : {rxd, q.rx_shifter[7:1]};
            d.rx_bits = 4'(q.rx_bits + 1'b1);
            if (q.rx_bits == (len8 ? 4'h7 : 4'h6)) begin
              d.rx_state = par_on ? UTR_RX_PAR : UTR_RX_STOP;
            end
          end
        end
        UTR_RX_PAR: begin
          if (rx_last) begin
            d.rx_par = rxd;
            d.rx_state = UTR_RX_STOP;
          end
        end
        UTR_RX_STOP: begin
          // Only the first stop bit is checked
          if (rx_last) begin
            d.rx_state = UTR_RX_IDLE;
          end
        end
        default: d.rx_state = UTR_RX_IDLE;
      endcase
    end
    // Reads clear first so that a same-cycle event still sets
    if (rd_err) begin
      d.rx_error_status = '0;
    end
    if (rd_rxb) begin
      d.rx_full = 1'b0;
    end
    if (overrun) begin
      d.rx_error_status[UTR_ERR_OVE] = 1'b1;
      d.rx_done = route;
      d.rx_err_irq = !route;
    end
    if (pop) begin
      d.rx_holding_reg = fifo_out[7:0];
      d.rx_full = 1'b1;
      d.rx_error_status[UTR_ERR_PE] = q.rx_error_status[UTR_ERR_PE]
                                      | fifo_out[9];
      d.rx_error_status[UTR_ERR_FE] = q.rx_error_status[UTR_ERR_FE]
                                      | fifo_out[8];
      d.rx_done = !pop_err || route;
      d.rx_err_irq = pop_err && !route;
    end
    // Transmitter
    d.tx_cnt = (!q.tx_busy || tx_last) ? '0 : CW'(q.tx_cnt + 1'b1);
    if (q.tx_busy && tx_last) begin
      d.tx_shifter = {1'b1, q.tx_shifter[UTR_FRAME_W-1:1]};
      d.tx_bits = 4'(q.tx_bits - 1'b1);
      if (tx_end) begin
        d.tx_busy = 1'b0;
        d.tx_fin = 1'b1;
      end
    end
    if (tx_load) begin
      d.tx_shifter = tx_frame;
      d.tx_bits = tx_count;
      d.tx_busy = 1'b1;
      d.tx_cnt = '0;
      d.txbuf_full_flag = 1'b0;
    end
    if (wr_txb) begin
      d.txbuf_full_flag = 1'b1;
    end
    if (!tx_en) begin
      d.tx_busy = 1'b0;
      d.txbuf_full_flag = 1'b0;
      d.tx_fin = 1'b0;
    end
    d.tx_out = d.tx_busy ? d.tx_shifter[0] : 1'b1;
  end

  always_ff @(posedge clk_in or negedge core_rst_n) begin
    if (!core_rst_n) begin
      q <= CORE_RST;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // Register file
  always_comb begin
    rn = r;
    if (reg_wr_in && utr_hit(reg_addr_in, UTR_OFS_MODE)) begin
      rn.mode = reg_wdata_in;
    end
    if (wr_txb) begin
      rn.txb = reg_wdata_in;
    end
    if (reg_rd_in) begin
      case (reg_addr_in)
        UTR_OFS_MODE: rn.rdata = r.mode;
        UTR_OFS_RXB: rn.rdata = q.rx_holding_reg;
        UTR_OFS_ERR: rn.rdata = {5'h00, q.rx_error_status};
        UTR_OFS_TXB: rn.rdata = r.txb;
        UTR_OFS_TXS: rn.rdata = {6'h00, q.txbuf_full_flag, q.tx_busy};
        default: rn.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r <= '{mode: UTR_MODE_RST, txb: UTR_TXB_RST, rdata: 8'h00};
    end else begin
      r <= rn;
    end
  end

  assign reg_rdata_out = r.rdata;
  assign serial_out_pin_out = q.tx_out;
  assign rx_done_irq_out = q.rx_done;
  assign rx_error_irq_out = q.rx_err_irq;
  assign tx_done_irq_out = q.tx_done;

  // ==========================================================
  // Checks
  chk_rx_lsb_seven: assert property (
    @(posedge clk_in) disable iff (!core_rst_n)
    (rx_complete && !overrun && !len8 && !msb_first_in)
    |-> !rx_data[7])
    else $error("7-bit LSB-first data has bit 7 set");

  chk_rx_msb_seven: assert property (
    @(posedge clk_in) disable iff (!core_rst_n)
    (rx_complete && !len8 && msb_first_in) |-> !rx_data[0])
    else $error("7-bit MSB-first data has bit 0 set");

  chk_overrun_drop: assert property (
    @(posedge clk_in) disable iff (!core_rst_n)
    (overrun && q.rx_full && !rd_rxb)
    |=> $stable(q.rx_holding_reg) && q.rx_error_status[UTR_ERR_OVE])
    else $error("overrun character reached the buffer");

  chk_rxbuf_readonly: assert property (
    @(posedge clk_in) disable iff (!core_rst_n)
    (reg_wr_in && utr_hit(reg_addr_in, UTR_OFS_RXB) && !pop)
    |=> $stable(q.rx_holding_reg))
    else $error("receive buffer changed by a write");

  chk_txbuf_write: assert property (
    @(posedge clk_in) disable iff (!core_rst_n)
    (wr_txb && tx_en) |=> (q.txbuf_full_flag || q.tx_busy)
    ##1 q.tx_busy)
    else $error("transmit buffer write did not start sending");

  chk_first_load: assert property (
    @(posedge clk_in) disable iff (!core_rst_n)
    (tx_en && !q.tx_busy && q.txbuf_full_flag)
    |=> q.tx_busy && !serial_out_pin_out && !q.txbuf_full_flag)
    else $error("first character not loaded at once");

  chk_load_before_done: assert property (
    @(posedge clk_in) disable iff (!core_rst_n)
    (tx_end && tx_load) |=> q.tx_busy ##1 tx_done_irq_out)
    else $error("continuous load not ahead of done pulse");

  chk_power_off: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    !power |-> serial_out_pin_out && !q.rx_full && !q.tx_busy
    && q.rx_holding_reg == UTR_RXB_RST && q.rx_error_status == 3'h0)
    else $error("powered-off unit not held in reset");

  chk_tx_disable: assert property (
    @(posedge clk_in) disable iff (!core_rst_n)
    (!tx_en && $past(!tx_en)) |-> serial_out_pin_out && !q.tx_busy
    && !q.txbuf_full_flag)
    else $error("disabled transmitter still active");

  chk_rx_disable: assert property (
    @(posedge clk_in) disable iff (!core_rst_n)
    !rx_en |=> q.rx_state == UTR_RX_IDLE && !fifo_out_valid)
    else $error("disabled receiver not reset");

  chk_zero_parity: assert property (
    @(posedge clk_in) disable iff (!core_rst_n)
    (ps == UTR_PAR_ZERO) |-> !rx_pe)
    else $error("zero parity flagged an error");

  chk_err_route: assert property (
    @(posedge clk_in) disable iff (!core_rst_n)
    (pop && pop_err) |=> (rx_done_irq_out == $past(route))
    && (rx_error_irq_out == !$past(route)))
    else $error("receive error routed to the wrong interrupt");

  chk_start_low: assert property (
    @(posedge clk_in) disable iff (!core_rst_n)
    (rx_en && q.rx_state == UTR_RX_IDLE && !rxd)
    |=> q.rx_state == UTR_RX_START)
    else $error("low input did not start reception");

  chk_done_after_load: assert property (
    @(posedge clk_in) disable iff (!core_rst_n)
    (pop && !pop_err) |=> rx_done_irq_out && !rx_error_irq_out
    && q.rx_full && q.rx_holding_reg == $past(fifo_out[7:0]))
    else $error("clean character without done interrupt");

endmodule

// ---- sim/utr_serial_node.sv ----
`timescale 1ns/100ps
// ==========
// Remote serial node
module utr_serial_node #(
  parameter int BC = 4
) (
  // Clock
  input wire logic clk_in,
  // Serial link
  output logic line_out,
  input wire logic line_in
);
  logic par = 1'b0;
  int cyc = 0;
  logic [7:0] got[$];
  logic pgot[$];
  int t_start[$];

  initial line_out = 1'b1;
  always @(posedge clk_in) cyc <= cyc + 1;

  task automatic hold_bit(input logic v);
    line_out = v;
    repeat (BC) @(posedge clk_in);
    #1;
  endtask

  // Start, data, optional parity, one stop; flip spoils parity or stop
  task automatic send(input logic [7:0] d, input int k, input logic m,
                      input logic [1:0] pm, input logic flip);
    logic p;
    p = pm[1] & (^d ^ ~pm[0]);
    hold_bit(1'b0);
    for (int i = 0; i < k; i++) hold_bit(m ? d[7-i] : d[i]);
    if (pm != 2'b00) hold_bit(p ^ flip);
    hold_bit(!(flip && pm == 2'b00));
    line_out = 1'b1;
  endtask

  // Falling edge keeps sampling clear of the launch edge
  initial begin : rx_side
    logic [7:0] w;
    forever begin
      @(negedge clk_in);
      if (line_in === 1'b0) begin
        t_start.push_back(cyc);
        repeat (BC / 2) @(negedge clk_in);
        w = 8'h00;
        for (int i = 0; i < 8; i++) begin
          repeat (BC) @(negedge clk_in);
          w[i] = line_in;
        end
        if (par) begin
          repeat (BC) @(negedge clk_in);
          pgot.push_back(line_in);
        end
        repeat (BC) @(negedge clk_in);
        got.push_back(w);
      end
    end
  end
endmodule

// ---- sim/utr_core_test.sv ----
`timescale 1ns/100ps
module utr_core_test;
  import utr_pkg::*;
  localparam int BC = 4;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic msb = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic sin, sout, rx_irq, er_irq, tx_irq;
  int err_count = 0;
  int checked = 0;
  int n_rx = 0;
  int n_er = 0;
  int n_tx = 0;
  int base;
  logic [7:0] pm_mode[4] = '{8'hAC, 8'hB4, 8'hBC, 8'hA4};
  logic [7:0] pm_dat[4] = '{8'h81, 8'h81, 8'h07, 8'h55};
  logic pm_flip[4] = '{1'b1, 1'b1, 1'b0, 1'b1};
  logic [7:0] pm_err[4] = '{8'h00, 8'h04, 8'h00, 8'h02};

  utr_core #(.BIT_CYCLES(BC), .FIFO_DEPTH(8)) uut (
    .clk_in(clk_in), .rst_n_in(rst_n_in),
    .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .serial_in_pin_in(sin), .serial_out_pin_out(sout),
    .msb_first_in(msb), .rx_done_irq_out(rx_irq),
    .rx_error_irq_out(er_irq), .tx_done_irq_out(tx_irq)
  );
  utr_serial_node #(.BC(BC)) node (
    .clk_in(clk_in), .line_out(sin), .line_in(sout)
  );

  initial begin
    forever #12.5 clk_in = ~clk_in;
  end

  // Pulses last one cycle, so count them away from the launch edge
  always @(negedge clk_in) begin
    if (rx_irq === 1'b1) n_rx++;
    if (er_irq === 1'b1) n_er++;
    if (tx_irq === 1'b1) n_tx++;
  end

  // ==========
  // Access tasks
  task automatic tick(input int c);
    repeat (c) @(posedge clk_in);
    #1;
  endtask

  task automatic chk(input string s, input logic [7:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", s, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    tick(1);
    wr = 1'b0;
    tick(1);
  endtask

  task automatic rd_chk(input string s, input logic [15:0] a,
                        input logic [7:0] e);
    addr = a;
    rd = 1'b1;
    tick(1);
    rd = 1'b0;
    chk(s, rdata, e);
    tick(1);
  endtask

  task automatic mode_set(input logic [7:0] m);
    wr_reg(UTR_OFS_MODE, 8'h80);
    tick(2);
    wr_reg(UTR_OFS_MODE, m);
  endtask

  task automatic wait_rx(input int c);
    int k;
    k = 0;
    while (node.got.size() < c && k < 3000) begin
      tick(1);
      k++;
    end
    if (k == 3000) begin
      err_count++;
      wrap_up();
    end
  endtask

  task automatic test_end(input string s);
    $display("test %s done", s);
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ==========
  // Main sequence
  initial begin : main
    tick(4);
    rst_n_in = 1'b1;
    tick(1);
    rd_chk("mode", UTR_OFS_MODE, UTR_MODE_RST);
    rd_chk("rxb", UTR_OFS_RXB, UTR_RXB_RST);
    rd_chk("txb", UTR_OFS_TXB, UTR_TXB_RST);
    rd_chk("unmapped", 16'hFF5F, 8'h00);
    wr_reg(UTR_OFS_MODE, 8'h80);
    wr_reg(UTR_OFS_MODE, 8'hE4);
    wr_reg(UTR_OFS_RXB, 8'h12);
    rd_chk("rxb write", UTR_OFS_RXB, 8'hFF);
    test_end("defaults");

    node.send(8'h3C, 8, 1'b0, 2'b00, 1'b0);
    tick(4);
    rd_chk("rx8", UTR_OFS_RXB, 8'h3C);
    mode_set(8'hA0);
    node.send(8'h6B, 7, 1'b0, 2'b00, 1'b0);
    tick(4);
    rd_chk("lsb7", UTR_OFS_RXB, 8'h6B);
    msb = 1'b1;
    node.send(8'hD7, 7, 1'b1, 2'b00, 1'b0);
    tick(4);
    rd_chk("msb7", UTR_OFS_RXB, 8'hD6);
    msb = 1'b0;
    for (int i = 0; i < 4; i++) begin
      mode_set(pm_mode[i]);
      node.send(pm_dat[i], 8, 1'b0, pm_mode[i][4:3], pm_flip[i]);
      tick(4);
      rd_chk("err", UTR_OFS_ERR, pm_err[i]);
      rd_chk("rxb par", UTR_OFS_RXB, pm_dat[i]);
    end
    chk("rx irqs", 8'(n_rx), 8'h05);
    chk("err irqs", 8'(n_er), 8'h02);
    test_end("receive");

    mode_set(8'hF4);
    node.par = 1'b1;
    wr_reg(UTR_OFS_TXB, 8'h81);
    wait_rx(1);
    tick(12);
    chk("tx par", {7'h00, node.pgot[0]}, 8'h01);
    chk("tx8", node.got[0], 8'h81);
    node.par = 1'b0;
    mode_set(8'h86);
    wr_reg(UTR_OFS_MODE, 8'hE6);
    addr = UTR_OFS_TXB;
    wdata = 8'hA5;
    wr = 1'b1;
    tick(1);
    wr = 1'b0;
    chk("idle", {7'h00, sout}, 8'h01);
    tick(1);
    chk("start", {7'h00, sout}, 8'h00);
    rd_chk("txs", UTR_OFS_TXS, 8'h01);
    wr_reg(UTR_OFS_TXB, 8'h3C);
    wait_rx(3);
    tick(12);
    chk("cont1", node.got[1], 8'hA5);
    chk("cont2", node.got[2], 8'h3C);
    chk("gap", 8'(node.t_start[2] - node.t_start[1]), 8'(BC * 11));
    chk("tx irqs", 8'(n_tx), 8'h03);
    rd_chk("txb rd", UTR_OFS_TXB, 8'h3C);
    test_end("transmit");

    mode_set(8'hA5);
    base = n_rx;
    for (int i = 0; i < 10; i++) begin
      node.send(8'h10 + 8'(i), 8, 1'b0, 2'b00, 1'b0);
    end
    tick(4);
    chk("ovr irqs", 8'(n_rx - base), 8'h02);
    chk("err irqs", 8'(n_er), 8'h02);
    rd_chk("ovr", UTR_OFS_ERR, 8'h01);
    for (int i = 0; i < 9; i++) begin
      rd_chk("drain", UTR_OFS_RXB, 8'h10 + 8'(i));
    end
    chk("rx irqs", 8'(n_rx - base), 8'h0A);
    test_end("overrun");

    mode_set(8'hE4);
    wr_reg(UTR_OFS_TXB, 8'h00);
    tick(3);
    chk("low", {7'h00, sout}, 8'h00);
    wr_reg(UTR_OFS_MODE, 8'hA4);
    chk("abort", {7'h00, sout}, 8'h01);
    rd_chk("txs off", UTR_OFS_TXS, 8'h00);
    wr_reg(UTR_OFS_MODE, 8'h80);
    wr_reg(UTR_OFS_MODE, 8'h00);
    rd_chk("rxb off", UTR_OFS_RXB, 8'hFF);
    rd_chk("err off", UTR_OFS_ERR, 8'h00);
    chk("pin off", {7'h00, sout}, 8'h01);
    test_end("power");
    wrap_up();
  end
endmodule
